/* File: qpsc_pkg.sv */
// Purpose: shared constants, field layouts and states of the quad wiper serial decoder
// Assumes: mclk at 20 MHz, serial clock much slower than mclk
// Notes: opcodes and field layouts are the serial protocol's own encodings
package qpsc_pkg;
   localparam int MCLK_HZ = 20_000_000;
   localparam int MCLK_MHZ = MCLK_HZ / 1_000_000;
   localparam int NV_WRITE_TIME_MS = 10;
   localparam int NV_WRITE_CYC_DEF = NV_WRITE_TIME_MS * (MCLK_HZ / 1000);
   localparam int WIPER_RESP_TIME_NS = 1000;
   // least time, so rounded up
   localparam int WIPER_RESP_CYC = (WIPER_RESP_TIME_NS * MCLK_MHZ + 999) / 1000;
   localparam int NV_CNT_W = 24;
   localparam int LAT_W = 8;
   localparam int CH_N = 4;
   localparam int DR_N = 16;
   localparam int WCR_W = 6;
   localparam int TAP_N = 64;
   localparam logic [WCR_W-1:0] WCR_MAX = 6'h3f;
   localparam logic [WCR_W-1:0] WCR_MIN = 6'h00;
   localparam logic [WCR_W-1:0] WCR_RST = 6'h00;
   localparam logic [TAP_N-1:0] TAP_ONE = 64'h1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [1:0] FIELD_ZERO = 2'h0;
   localparam logic [6:0] STAT_PAD = 7'h00;
   localparam logic [3:0] OP_RD_WCR = 4'h9;
   localparam logic [3:0] OP_WR_WCR = 4'ha;
   localparam logic [3:0] OP_RD_DR = 4'hb;
   localparam logic [3:0] OP_WR_DR = 4'hc;
   localparam logic [3:0] OP_DR2WCR = 4'hd;
   localparam logic [3:0] OP_WCR2DR = 4'he;
   localparam logic [3:0] OP_GDR2WCR = 4'h1;
   localparam logic [3:0] OP_GWCR2DR = 4'h8;
   localparam logic [3:0] OP_INCDEC = 4'h2;
   localparam logic [7:0] STATUS_INSTR = 8'h51;

   typedef struct packed {
      logic [3:0] dev_type;
      logic [1:0] zeros;
      logic [1:0] bus_addr;
   } qpsc_id_t;

   typedef struct packed {
      logic [3:0] opcode;
      logic preset_index_hi;
      logic preset_index_lo;
      logic channel_select_hi;
      logic channel_select_lo;
   } qpsc_instr_t;

   typedef enum logic [1:0] {PEND_NONE, PEND_ONE, PEND_ALL} qpsc_pend_t;

   typedef enum logic [2:0] {
      S_IDLE, S_ID, S_INSTR, S_DATA_IN, S_DATA_OUT, S_STEP, S_DONE, S_IGNORE
   } qpsc_state_t;
endpackage

/* File: qpsc_decoder.sv */
// Purpose: serial command decoder for four wiper counters and sixteen preset stores
// Assumes: serial pins are asynchronous to mclk and sampled by it; sck period >= 8 mclk
// Notes: preset stores are held in flops here; the nonvolatile array itself sits outside
`timescale 1ns/10ps
module qpsc_decoder
   import qpsc_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE_CODE = 4'ha, // arbitrary device-type code
   parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEF
)
(
   input wire logic mclk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic sck, // serial clock pin
   input wire logic cs_n, // chip select pin, active low
   input wire logic si, // serial data in pin
   input wire logic [1:0] bus_select_pins, // device address straps
   output logic so, // serial data out
   output logic so_oe, // serial out drive enable
   output logic wip, // internal nonvolatile write running
   output logic [CH_N-1:0][TAP_N-1:0] wiper_tap // one-hot tap switch enables
);

   function automatic logic [3:0] dr_idx(input qpsc_instr_t ins);
      dr_idx = {ins.channel_select_hi, ins.channel_select_lo,
                ins.preset_index_hi, ins.preset_index_lo};
   endfunction

   function automatic logic [1:0] ch_of(input qpsc_instr_t ins);
      ch_of = {ins.channel_select_hi, ins.channel_select_lo};
   endfunction

   function automatic logic [1:0] ri_of(input qpsc_instr_t ins);
      ri_of = {ins.preset_index_hi, ins.preset_index_lo};
   endfunction

   logic sck_s1_r, sck_s2_r, sck_d_r;
   logic cs_s1_r, cs_s2_r, cs_d_r;
   logic si_s1_r, si_s2_r;
   logic [1:0] adr_s1_r, adr_s2_r;
   logic sck_rise, sck_fall, cs_rise, cs_fall, byte_done;
   logic [7:0] rx_byte;
   qpsc_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   qpsc_instr_t instr_r;
   qpsc_instr_t ins_rx;
   qpsc_id_t id_rx;
   logic [7:0] tx_r;
   logic so_r;
   logic [WCR_W-1:0] wiper_position_counter_r [CH_N];
   logic [WCR_W-1:0] pot_preset_store_r [DR_N];
   qpsc_pend_t pend_r;
   logic [3:0] pend_idx_r;
   logic [1:0] pend_ri_r;
   logic [WCR_W-1:0] pend_val_r;
   logic [NV_CNT_W-1:0] nv_cnt_r;
   logic [LAT_W-1:0] lat_cnt_r;
   logic [CH_N-1:0][TAP_N-1:0] tap_r;
   logic ev_wr_wcr, ev_dr2wcr, ev_gdr2wcr, ev_step, wcr_chg;
   logic ins_ok, ins_read;
   logic [7:0] rd_byte;

   // first stages feed only the second stages
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_d_r <= 1'b0;
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_d_r <= 1'b1;
         si_s1_r <= 1'b0;
         si_s2_r <= 1'b0;
         adr_s1_r <= FIELD_ZERO;
         adr_s2_r <= FIELD_ZERO;
      end
      else
      begin
         sck_s1_r <= sck;
         sck_s2_r <= sck_s1_r;
         sck_d_r <= sck_s2_r;
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_d_r <= cs_s2_r;
         si_s1_r <= si;
         si_s2_r <= si_s1_r;
         adr_s1_r <= bus_select_pins;
         adr_s2_r <= adr_s1_r;
      end
   end

   assign sck_rise = sck_s2_r & ~sck_d_r & ~cs_s2_r;
   assign sck_fall = ~sck_s2_r & sck_d_r & ~cs_s2_r;
   assign cs_rise = cs_s2_r & ~cs_d_r;
   assign cs_fall = ~cs_s2_r & cs_d_r;
   assign rx_byte = {shift_r, si_s2_r};
   assign byte_done = sck_rise && (bit_cnt_r == BIT_LAST);
   assign ins_rx = qpsc_instr_t'(rx_byte);
   assign id_rx = qpsc_id_t'(rx_byte);

   // instruction validity and whether it answers with a data byte
   always_comb
   begin
      ins_ok = 1'b0;
      ins_read = 1'b0;
      case (ins_rx.opcode)
         OP_RD_WCR:
         begin
            ins_ok = (ri_of(ins_rx) == FIELD_ZERO);
            ins_read = 1'b1;
         end
         OP_WR_WCR: ins_ok = (ri_of(ins_rx) == FIELD_ZERO);
         OP_RD_DR:
         begin
            ins_ok = 1'b1;
            ins_read = 1'b1;
         end
         OP_WR_DR, OP_DR2WCR, OP_WCR2DR: ins_ok = 1'b1;
         OP_GDR2WCR, OP_GWCR2DR: ins_ok = (ch_of(ins_rx) == FIELD_ZERO);
         OP_INCDEC: ins_ok = (ri_of(ins_rx) == FIELD_ZERO);
         default:
         begin
            ins_ok = (rx_byte == STATUS_INSTR);
            ins_read = 1'b1;
         end
      endcase
   end

   // serial framing state machine
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= S_IDLE;
         bit_cnt_r <= BIT_FIRST;
         shift_r <= '0;
         instr_r <= '0;
      end
      else if (cs_s2_r)
      begin
         state_r <= S_IDLE;
         bit_cnt_r <= BIT_FIRST;
      end
      else if (cs_fall)
      begin
         state_r <= S_ID;
         bit_cnt_r <= BIT_FIRST;
      end
      else if (sck_rise)
      begin
         shift_r <= rx_byte[6:0];
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_done)
         begin
            case (state_r)
               S_ID:
                  // zero bits are not checked so a sloppy host still gets through
                  if (id_rx.dev_type == DEV_TYPE_CODE && id_rx.bus_addr == adr_s2_r)
                     state_r <= S_INSTR;
                  else
                     state_r <= S_IGNORE;
               S_INSTR:
               begin
                  instr_r <= ins_rx;
                  if (!ins_ok)
                     state_r <= S_IGNORE;
                  else if (ins_read)
                     state_r <= S_DATA_OUT;
                  else if (ins_rx.opcode == OP_WR_WCR || ins_rx.opcode == OP_WR_DR)
                     state_r <= S_DATA_IN;
                  else if (ins_rx.opcode == OP_INCDEC)
                     state_r <= S_STEP;
                  else
                     state_r <= S_DONE;
               end
               S_DATA_IN, S_DATA_OUT: state_r <= S_DONE;
               default: state_r <= state_r;
            endcase
         end
      end
   end

   // volatile wiper events
   always_comb
   begin
      ev_wr_wcr = byte_done && state_r == S_DATA_IN && instr_r.opcode == OP_WR_WCR;
      ev_dr2wcr = byte_done && state_r == S_INSTR && ins_ok && ins_rx.opcode == OP_DR2WCR;
      ev_gdr2wcr = byte_done && state_r == S_INSTR && ins_ok && ins_rx.opcode == OP_GDR2WCR;
      ev_step = sck_rise && state_r == S_STEP;
   end

   assign wcr_chg = ev_wr_wcr | ev_dr2wcr | ev_gdr2wcr | ev_step;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < CH_N; c++)
            wiper_position_counter_r[c] <= WCR_RST;
      end
      else if (ev_wr_wcr)
         wiper_position_counter_r[ch_of(instr_r)] <= rx_byte[WCR_W-1:0];
      else if (ev_dr2wcr)
         wiper_position_counter_r[ch_of(ins_rx)] <= pot_preset_store_r[dr_idx(ins_rx)];
      else if (ev_gdr2wcr)
      begin
         for (int c = 0; c < CH_N; c++)
            wiper_position_counter_r[c] <= pot_preset_store_r[{c[1:0], ri_of(ins_rx)}];
      end
      else if (ev_step)
      begin
         if (si_s2_r && wiper_position_counter_r[ch_of(instr_r)] != WCR_MAX)
            wiper_position_counter_r[ch_of(instr_r)] <=
               wiper_position_counter_r[ch_of(instr_r)] + 6'h01;
         else if (!si_s2_r && wiper_position_counter_r[ch_of(instr_r)] != WCR_MIN)
            wiper_position_counter_r[ch_of(instr_r)] <=
               wiper_position_counter_r[ch_of(instr_r)] - 6'h01;
      end
   end

   // nonvolatile writes are queued and only land on deselect; a write request whose deselect
   // comes while a previous write runs is dropped, as the array cannot take it
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pend_r <= PEND_NONE;
         pend_idx_r <= '0;
         pend_ri_r <= FIELD_ZERO;
         pend_val_r <= WCR_RST;
         for (int i = 0; i < DR_N; i++)
            pot_preset_store_r[i] <= WCR_RST;
      end
      else if (cs_rise)
      begin
         pend_r <= PEND_NONE;
         if (pend_r == PEND_ONE && !wip)
            pot_preset_store_r[pend_idx_r] <= pend_val_r;
         else if (pend_r == PEND_ALL && !wip)
         begin
            for (int c = 0; c < CH_N; c++)
               pot_preset_store_r[{c[1:0], pend_ri_r}] <= wiper_position_counter_r[c];
         end
      end
      else if (cs_fall)
         pend_r <= PEND_NONE;
      else if (byte_done && state_r == S_DATA_IN && instr_r.opcode == OP_WR_DR)
      begin
         pend_r <= PEND_ONE;
         pend_idx_r <= dr_idx(instr_r);
         pend_val_r <= rx_byte[WCR_W-1:0];
      end
      else if (byte_done && state_r == S_INSTR && ins_ok && ins_rx.opcode == OP_WCR2DR)
      begin
         pend_r <= PEND_ONE;
         pend_idx_r <= dr_idx(ins_rx);
         pend_val_r <= wiper_position_counter_r[ch_of(ins_rx)];
      end
      else if (byte_done && state_r == S_INSTR && ins_ok && ins_rx.opcode == OP_GWCR2DR)
      begin
         pend_r <= PEND_ALL;
         pend_ri_r <= ri_of(ins_rx);
      end
      else if (sck_rise && state_r == S_DONE)
         pend_r <= PEND_NONE; // clocks past the frame void the write
   end

   // write-cycle timer
   always_ff @(posedge mclk)
   begin
      if (rst)
         nv_cnt_r <= '0;
      else if (cs_rise && pend_r != PEND_NONE && !wip)
         nv_cnt_r <= NV_CNT_W'(NV_WRITE_CYC);
      else if (nv_cnt_r != '0)
         nv_cnt_r <= nv_cnt_r - 1'b1;
   end

   assign wip = (nv_cnt_r != '0);

   // taps follow the counters after the response latency; a burst of steps
   // restarts the wait, so the taps settle once stepping pauses
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lat_cnt_r <= '0;
         for (int c = 0; c < CH_N; c++)
            tap_r[c] <= TAP_ONE << WCR_RST;
      end
      else if (wcr_chg)
         lat_cnt_r <= LAT_W'(WIPER_RESP_CYC);
      else if (lat_cnt_r != '0)
      begin
         lat_cnt_r <= lat_cnt_r - 1'b1;
         if (lat_cnt_r == LAT_W'(1))
         begin
            for (int c = 0; c < CH_N; c++)
               tap_r[c] <= TAP_ONE << wiper_position_counter_r[c];
         end
      end
   end

   assign wiper_tap = tap_r;

   // read data prepared at the end of the instruction byte
   always_comb
   begin
      case (ins_rx.opcode)
         OP_RD_WCR: rd_byte = {FIELD_ZERO, wiper_position_counter_r[ch_of(ins_rx)]};
         OP_RD_DR: rd_byte = {FIELD_ZERO, pot_preset_store_r[dr_idx(ins_rx)]};
         default: rd_byte = {STAT_PAD, wip};
      endcase
   end

   // serial out shifts on falling sck, msb first
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tx_r <= '0;
         so_r <= 1'b0;
      end
      else if (byte_done && state_r == S_INSTR && ins_ok && ins_read)
         tx_r <= rd_byte;
      else if (sck_fall && state_r == S_DATA_OUT)
      begin
         so_r <= tx_r[7];
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   assign so = so_r;
   assign so_oe = (state_r == S_DATA_OUT) && !cs_s2_r;

endmodule

/* File: qpsc_decoder_asserts.sv */
// Purpose: port-level checks for the quad wiper serial decoder
// Assumes: the host always completes the frames it starts
// Notes: wip and read-out spans are counted in helper counters
`timescale 1ns/10ps
module qpsc_decoder_asserts
   import qpsc_pkg::*;
#(
   parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEF
)
(
   input wire logic mclk, // clock
   input wire logic rst, // reset
   input wire logic sck, // serial clock
   input wire logic cs_n, // chip select
   input wire logic si, // serial in
   input wire logic [1:0] bus_select_pins, // address straps
   input wire logic so, // serial out
   input wire logic so_oe, // out enable
   input wire logic wip, // write running
   input wire logic [CH_N-1:0][TAP_N-1:0] wiper_tap // taps
);
   int wip_cnt_r;
   int oe_cnt_r;
   always_ff @(posedge mclk)
   begin
      wip_cnt_r <= (rst || !wip) ? 0 : wip_cnt_r + 1;
   end
   always_ff @(posedge mclk)
   begin
      oe_cnt_r <= (rst || !so_oe) ? 0 : oe_cnt_r + 1;
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   oe_idle_a: assert property (cs_n [*6] |-> !so_oe)
      else $error("serial out driven while deselected");
   tap_onehot_a: assert property ($onehot(wiper_tap[0]) && $onehot(wiper_tap[1])
      && $onehot(wiper_tap[2]) && $onehot(wiper_tap[3]))
      else $error("tap enables not one-hot");
   tap_reset_a: assert property ($fell(rst) |-> wiper_tap == {CH_N{TAP_ONE}})
      else $error("taps not at bottom after reset");
   wip_len_a: assert property ($fell(wip) |-> wip_cnt_r == NV_WRITE_CYC)
      else $error("write time wrong");
   wip_start_a: assert property ($rose(wip) |-> cs_n && !$past(cs_n, 8))
      else $error("write started away from deselect");
   wip_hold_a: assert property ($rose(wip) |=> wip [*8])
      else $error("busy flag dropped early");
   oe_start_a: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 8))
      else $error("drive began outside a frame");
   oe_len_a: assert property ($fell(so_oe) && !cs_n |-> oe_cnt_r >= 62 && oe_cnt_r <= 66)
      else $error("read byte not eight bits long");
endmodule
bind qpsc_decoder qpsc_decoder_asserts #(.NV_WRITE_CYC(NV_WRITE_CYC)) qpsc_decoder_asserts_inst (
   .mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .bus_select_pins(bus_select_pins),
   .so(so), .so_oe(so_oe), .wip(wip), .wiper_tap(wiper_tap));

/* File: qpsc_host.sv */
// Purpose: serial bus master model driving the decoder's pins
// Assumes: sck period 8 mclk (400 ns), sck low and still between frames
// Notes: read bits taken just before each rise, while the device still drives so
`timescale 1ns/10ps
module qpsc_host
(
   input wire logic mclk, // clock
   output logic sck, // serial clock
   output logic cs_n, // chip select, active low
   output logic si, // serial data to device
   input wire logic so, // serial data from device
   input wire logic so_oe // device drive enable
);
   logic so_line;
   // no pull on the line, so a released output floats
   assign so_line = so_oe ? so : 1'bz;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = n - 1; i >= 0; i--)
      begin
         si <= tx[i];
         repeat (4) @(posedge mclk);
         // the last bit loses its drive soon after the 24th rise, so take it first
         rx = {rx[30:0], so_line};
         sck <= 1'b1;
         repeat (4) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si; // leave no stale level on the line
      repeat (8) @(posedge mclk);
   endtask
endmodule

/* File: test_quad_pot_spi_command_decoder.sv */
// Purpose: self-checking bench for the quad wiper serial decoder
// Assumes: short nonvolatile write time set by parameter
// Notes: expected values come from the command encodings alone
`timescale 1ns/10ps
module test_quad_pot_spi_command_decoder;
   import qpsc_pkg::*;
   localparam logic [3:0] DEV = 4'ha; // arbitrary type code
   localparam logic [1:0] ADDR = 2'h2;
   localparam int NV = 400;
   logic mclk;
   logic rst;
   logic sck;
   logic cs_n;
   logic si;
   logic so;
   logic so_oe;
   logic wip;
   logic [CH_N-1:0][TAP_N-1:0] wiper_tap;
   logic [31:0] rx;
   logic [1:0] pins;
   logic [7:0] id;
   int err_count;
   int checks;
   qpsc_decoder #(.DEV_TYPE_CODE(DEV), .NV_WRITE_CYC(NV)) qpsc_decoder_inst (.mclk(mclk),
      .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .bus_select_pins(pins), .so(so),
      .so_oe(so_oe), .wip(wip), .wiper_tap(wiper_tap));
   qpsc_host qpsc_host_inst (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe));
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] instr, input logic [7:0] data, input int n);
      qpsc_host_inst.frame({8'h00, id, instr, data} >> (24 - n), n, rx);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_reset;
      for (int c = 0; c < CH_N; c++)
      begin
         chk("tap reset", wiper_tap[c], TAP_ONE);
         cmd({OP_RD_WCR, 2'b00, 2'(c)}, 8'h00, 24);
         chk("wiper reset", rx[7:0], 8'h00);
      end
      cmd(STATUS_INSTR, 8'h00, 24);
      chk("status idle", rx[7:0], 8'h00);
      $display("reset test done");
   endtask
   task automatic t_wiper;
      logic [5:0] v;
      for (int c = 0; c < CH_N; c++)
      begin
         v = 6'h3c - 6'(c);
         // top two data bits set on purpose: they must be ignored
         cmd({OP_WR_WCR, 2'b00, 2'(c)}, {2'b11, v}, 24);
         chk("tap held", wiper_tap[c], TAP_ONE);
         repeat (12) @(posedge mclk);
         chk("tap moved", wiper_tap[c], TAP_ONE << v);
         cmd({OP_RD_WCR, 2'b00, 2'(c)}, 8'h00, 24);
         chk("wiper read", rx[7:0], {2'b00, v});
      end
      $display("wiper test done");
   endtask
   task automatic t_preset;
      cmd({OP_WR_DR, 4'b1101}, 8'h2a, 24);
      cmd(STATUS_INSTR, 8'h00, 24);
      chk("status busy", rx[7:0], 8'h01);
      repeat (NV) @(posedge mclk);
      cmd(STATUS_INSTR, 8'h00, 24);
      chk("status done", rx[7:0], 8'h00);
      cmd({OP_RD_DR, 4'b1101}, 8'h00, 24);
      chk("preset read", rx[7:0], 8'h2a);
      cmd({OP_DR2WCR, 4'b1101}, 8'h00, 16);
      cmd({OP_RD_WCR, 4'b0001}, 8'h00, 24);
      chk("copy to wiper", rx[7:0], 8'h2a);
      cmd({OP_WCR2DR, 4'b0001}, 8'h00, 16);
      repeat (NV) @(posedge mclk);
      cmd({OP_RD_DR, 4'b0001}, 8'h00, 24);
      chk("copy to preset", rx[7:0], 8'h2a);
      $display("preset test done");
   endtask
   task automatic t_global;
      for (int c = 0; c < CH_N; c++)
         cmd({OP_WR_WCR, 2'b00, 2'(c)}, 8'h10 + 8'(c), 24);
      cmd({OP_GWCR2DR, 4'b1000}, 8'h00, 16);
      repeat (NV) @(posedge mclk);
      for (int c = 0; c < CH_N; c++)
         cmd({OP_WR_WCR, 2'b00, 2'(c)}, 8'h00, 24);
      cmd({OP_GDR2WCR, 4'b1000}, 8'h00, 16);
      for (int c = 0; c < CH_N; c++)
      begin
         cmd({OP_RD_WCR, 2'b00, 2'(c)}, 8'h00, 24);
         chk("global copy", rx[7:0], 8'h10 + 8'(c));
      end
      $display("global test done");
   endtask
   task automatic t_step;
      cmd({OP_WR_WCR, 4'b0010}, 8'h3e, 24);
      cmd({OP_INCDEC, 4'b0010}, 8'he0, 21); // up three times, down twice
      cmd({OP_RD_WCR, 4'b0010}, 8'h00, 24);
      chk("step high", rx[7:0], 8'h3d);
      cmd({OP_WR_WCR, 4'b0010}, 8'h01, 24);
      cmd({OP_INCDEC, 4'b0010}, 8'h00, 19);
      cmd({OP_RD_WCR, 4'b0010}, 8'h00, 24);
      chk("step low", rx[7:0], 8'h00);
      $display("step test done");
   endtask
   task automatic t_refuse;
      id = {~DEV, 2'b00, ADDR};
      cmd(STATUS_INSTR, 8'h00, 24);
      chk("bad type", rx[7:0], 8'hzz);
      id = {DEV, 2'b00, ~ADDR};
      cmd({OP_WR_WCR, 4'b0011}, 8'h07, 24);
      id = {DEV, 2'b00, ADDR};
      cmd({OP_RD_WCR, 4'b0011}, 8'h00, 24);
      chk("bad address", rx[7:0], 8'h13);
      cmd({OP_WR_WCR, 4'b0111}, 8'h05, 24);
      cmd({OP_RD_WCR, 4'b0011}, 8'h00, 24);
      chk("bad index", rx[7:0], 8'h13);
      @(posedge mclk);
      pins <= ~ADDR;
      id = {DEV, 2'b00, ~ADDR};
      cmd({OP_WR_WCR, 4'b0011}, 8'h07, 24);
      cmd({OP_RD_WCR, 4'b0011}, 8'h00, 24);
      chk("moved address", rx[7:0], 8'h07);
      pins <= ADDR;
      id = {DEV, 2'b00, ADDR};
      $display("refuse test done");
   endtask
   initial
   begin
      rst = 1'b1;
      pins = ADDR;
      id = {DEV, 2'b00, ADDR};
      err_count = 0;
      checks = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset;
      t_wiper;
      t_preset;
      t_global;
      t_step;
      t_refuse;
      final_report;
   end
   initial
   begin
      // nearly three times the cycles the tests need
      repeat (30000) @(posedge mclk);
      err_count++;
      final_report;
   end
endmodule
